/* File: tb/lxd_load_exchange_decoder_tb.sv */
// Self-checking testbench of the load and exchange decoder.
`timescale 1ns/1ns
module lxd_load_exchange_decoder_tb;
	import lxd_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic slow = 1'b0;
	logic mem_req, mem_we, mem_ready, instr_done, illegal_op;
	logic [15:0] mem_addr, pc, sp;
	logic [7:0] mem_wdata, mem_rdata;
	logic [7:0] prog[$];
	int n_fail = 0;
	int num_checks = 0;
	int n_ill = 0;
	int cycles = 0;
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	lxd_load_exchange_decoder dut (.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_o(mem_req),
		.mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
		.mem_rdata_i(mem_rdata), .mem_ready_i(mem_ready), .instr_done_o(instr_done),
		.illegal_op_o(illegal_op), .pc_o(pc), .sp_o(sp));
	lxd_mem_model mem_model (.clk_i(clk_i), .slow_i(slow), .req_i(mem_req), .we_i(mem_we),
		.addr_i(mem_addr), .wdata_i(mem_wdata), .rdata_o(mem_rdata), .ready_o(mem_ready));
	//****************************************
	// Shared tasks
	//****************************************
	task automatic give_verdict();
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (exp !== got) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	// Reset, load the program at address 0 and run until n instructions end.
	task automatic run_prog(input int n, input logic slow_mode);
		int cnt;
		int guard;
		cnt = 0;
		guard = 0;
		n_ill = 0;
		@(posedge clk_i);
		rstn_i <= 1'b0;
		slow <= slow_mode;
		repeat (4) @(posedge clk_i);
		foreach (prog[i]) mem_model.mem[i] = prog[i];
		rstn_i <= 1'b1;
		while (cnt < n && guard < 600) begin
			@(posedge clk_i);
			#1;
			guard++;
			if (instr_done === 1'b1) cnt++;
			if (illegal_op === 1'b1) n_ill++;
		end
		chk("done count", n, cnt);
	endtask
	//****************************************
	// Scenarios
	//****************************************
	task automatic sc_basic();
		prog = '{8'h26, 8'h12, 8'h2E, 8'h34, 8'h06, 8'h5A, 8'h48, 8'h16, 8'h77, 8'h72,
			8'h79, 8'h32, 8'h00, 8'h30, 8'h22, 8'h00, 8'h20};
		run_prog(9, 1'b0);
		chk("store d", 16'h0077, mem_model.mem[16'h1234]);
		chk("copy b", 16'h005A, mem_model.mem[16'h3000]);
		chk("pair lo", 16'h0034, mem_model.mem[16'h2000]);
		chk("pair hi", 16'h0012, mem_model.mem[16'h2001]);
		chk("pc", 16'h0011, pc);
	endtask
	task automatic sc_index();
		prog = '{8'hDD, 8'h21, 8'h10, 8'h40, 8'hDD, 8'h36, 8'hFE, 8'h99, 8'hDD, 8'h7E, 8'hFE,
			8'hFD, 8'h21, 8'h00, 8'h50, 8'hFD, 8'h77, 8'h03, 8'h2A, 8'h0E, 8'h40,
			8'h22, 8'h00, 8'h60};
		run_prog(7, 1'b1);
		chk("imm store", 16'h0099, mem_model.mem[16'h400E]);
		chk("index y", 16'h0099, mem_model.mem[16'h5003]);
		chk("direct lo", 16'h0099, mem_model.mem[16'h6000]);
		chk("direct hi", 16'h0000, mem_model.mem[16'h6001]);
	endtask
	task automatic sc_stack();
		prog = '{8'h3E, 8'hAB, 8'h01, 8'h34, 8'h12, 8'hF5, 8'hC5, 8'hE1, 8'h22, 8'h00, 8'h70};
		run_prog(6, 1'b0);
		chk("push a", 16'h00AB, mem_model.mem[16'hFFFE]);
		chk("push f", 16'h0000, mem_model.mem[16'hFFFD]);
		chk("push hi", 16'h0012, mem_model.mem[16'hFFFC]);
		chk("push lo", 16'h0034, mem_model.mem[16'hFFFB]);
		chk("sp", 16'hFFFD, sp);
		chk("pop lo", 16'h0034, mem_model.mem[16'h7000]);
		chk("pop hi", 16'h0012, mem_model.mem[16'h7001]);
	endtask
	// Extended page pair moves, a load of second_pair and a store through it, a pop of acc_flag_pair.
	task automatic sc_ext();
		prog = '{8'h01, 8'hCD, 8'hAB, 8'hED, 8'h43, 8'h00, 8'h72, 8'hED, 8'h5B, 8'h00, 8'h72,
			8'h3A, 8'h01, 8'h72, 8'h12, 8'h31, 8'h00, 8'h00, 8'hF1, 8'h32, 8'h04, 8'h72};
		run_prog(8, 1'b1);
		chk("pair bc lo", 16'h00CD, mem_model.mem[16'h7200]);
		chk("pair bc hi", 16'h00AB, mem_model.mem[16'h7201]);
		chk("via de", 16'h00AB, mem_model.mem[16'hABCD]);
		chk("pop af", 16'h00CD, mem_model.mem[16'h7204]);
		chk("sp pop", 16'h0002, sp);
		chk("pc ext", 16'h0016, pc);
	endtask
	task automatic sc_swap();
		prog = '{8'h3E, 8'h11, 8'h08, 8'h3E, 8'h22, 8'h08, 8'h32, 8'h00, 8'h71, 8'h06, 8'h33,
			8'hD9, 8'h06, 8'h44, 8'hD9, 8'h78, 8'h32, 8'h01, 8'h71, 8'h76};
		run_prog(12, 1'b0);
		chk("acc swap", 16'h0011, mem_model.mem[16'h7100]);
		chk("bank swap", 16'h0033, mem_model.mem[16'h7101]);
		chk("illegal", 16'h0001, n_ill);
		chk("sp kept", 16'hFFFF, sp);
	endtask
	//****************************************
	// Main sequence and hang guard
	//****************************************
	// The ceiling is about twenty times the cycles the five programs need.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_fail++;
			give_verdict();
		end
	end
	initial begin
		sc_basic();
		sc_index();
		sc_stack();
		sc_swap();
		sc_ext();
		give_verdict();
	end
endmodule

/* File: tb/lxd_mem_model.sv */
// Behavioural program and data memory on the far side of the decoder.
`timescale 1ns/1ns
module lxd_mem_model (
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic ready_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;
	initial begin
		ready_o = 1'b0;
		last_r = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end
	// Slow mode toggles ready each cycle, so a wait cycle follows every answer.
	always @(posedge clk_i) begin
		ready_o <= slow_i ? ~ready_o : 1'b1;
		if (req_i && ready_o && we_i) begin
			mem[addr_i] <= wdata_i;
		end
		if (req_i && ready_o && !we_i) begin
			last_r <= mem[addr_i];
		end
	end
	// Bytes come back by address, so ascending fetches see the program in order.
	// Outside an answer the bus shows the inverse of the last byte read, never that byte itself.
	assign rdata_o = (req_i && !we_i && ready_o) ? mem[addr_i] : ~last_r;
endmodule

/* File: verilog/lxd_bank.sv */
// General register bank with its duplicate set and the two exchange paths.
`timescale 1ns/1ns
module lxd_bank (
	input wire logic clk_i,
	input wire logic rstn_i,
	lxd_rf_if.bank rf
);
	import lxd_pkg::*;
	lxd_bank_type s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < NREG; i++) begin
			// Exchange first; a write in the same cycle lands in the newly active set.
			if ((rf.swap_af && (i == R_A || i == R_F)) || (rf.swap_bank && i < N_MAIN)) begin // see [RULE10]
				s_nxt.main[i] = s_r.alt[i];
				s_nxt.alt[i] = s_r.main[i];
			end
		end
		if (rf.we_a) begin
			s_nxt.main[rf.sel_a] = rf.dat_a;
		end
		if (rf.we_b) begin
			s_nxt.main[rf.sel_b] = rf.dat_b;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= '{main: {NREG{RST_BYTE}}, alt: {NREG{RST_BYTE}}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rf.regs = s_r.main;
endmodule

/* File: verilog/lxd_ea.sv */
// Indexed address adder: index register plus signed displacement.
`timescale 1ns/1ns
module lxd_ea (
	input wire logic [lxd_pkg::AW-1:0] base_i,
	input wire logic [lxd_pkg::DW-1:0] disp_i,
	output logic [lxd_pkg::AW-1:0] ea_o
);
	import lxd_pkg::*;
	// The displacement is two's complement, so it is sign extended before the add.
	assign ea_o = base_i + {{(AW - DW){disp_i[DW-1]}}, disp_i}; // see [RULE12]
endmodule

/* File: verilog/lxd_load_exchange_decoder.sv */
// Decoder and sequencer for the load, stack and exchange instructions.
// Behaviour
// [RULE1] Indexed 8-bit load: prefix, opcode, displacement.
// [RULE2] Direct-address load: opcode, low, high address.
// [RULE3] Immediate register load is opcode plus operand.
// [RULE4] Indexed immediate store: prefix, 36, displacement, operand.
// [RULE5] Every pair loads and stores by direct address.
// [RULE6] Push decrements before each byte; accumulator first.
// [RULE7] Stack moves 16 bits, high byte pushed first.
// [RULE8] Pop reads low then high, incrementing each.
// [RULE9] Low byte follows opcode, high byte next.
// [RULE10] 08 swaps acc_flag_pair; D9 swaps general bank.
// [RULE11] Only push and pop move the stack pointer; the code also loads it by OP_SP_HL and by pair loads.
// [RULE12] Displacement is signed, added to index register.
// [RULE13] Opcode 48 copies B into C.
// [RULE14] Opcode 72 stores D through pointer_pair.
// [RULE15] Prefix redirects pointer_pair to an index register.
// [RULE16] Memory returns instruction bytes in ascending order.
`timescale 1ns/1ns
module lxd_load_exchange_decoder (
	input wire logic clk_i,
	input wire logic rstn_i,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [lxd_pkg::AW-1:0] mem_addr_o,
	output logic [lxd_pkg::DW-1:0] mem_wdata_o,
	input wire logic [lxd_pkg::DW-1:0] mem_rdata_i,
	input wire logic mem_ready_i,
	output logic instr_done_o,
	output logic illegal_op_o,
	output logic [lxd_pkg::AW-1:0] pc_o,
	output logic [lxd_pkg::AW-1:0] sp_o
);
	import lxd_pkg::*;

	lxd_core_type s_r, s_nxt;
	lxd_rf_if rf();
	logic [AW-1:0] idx, hl, ea, wp_val;
	logic wp_go, finish;
	logic [1:0] grp;
	logic [2:0] dst, src;
	logic [3:0] lo4;

	// Value of the register pair that a state names; pointer_pair follows the prefix.
	function automatic logic [AW-1:0] pair_of(input lxd_core_type c,
		input logic [NREG-1:0][DW-1:0] r);
		logic [AW-1:0] v;
		v = '0;
		unique case (c.pp)
			PP_BC: v = {r[R_B], r[R_C]};
			PP_DE: v = {r[R_D], r[R_E]};
			PP_HL: v = (c.pre == PRE_NONE) ? {r[R_H], r[R_L]} : ((c.pre == PRE_X) ? c.ix : c.iy);
			default: v = c.afsel ? {r[R_A], r[R_F]} : c.sp;
		endcase
		return v;
	endfunction

	lxd_bank u_bank (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.rf(rf.bank)
	);

	lxd_ea u_ea (
		.base_i(idx),
		.disp_i(mem_rdata_i),
		.ea_o(ea)
	);

	// ***********************************************
	// Sequencer
	// ***********************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.illegal = 1'b0;
		finish = 1'b0;
		wp_go = 1'b0;
		wp_val = '0;
		rf.we_a = 1'b0;
		rf.we_b = 1'b0;
		rf.sel_a = R_B;
		rf.sel_b = R_B;
		rf.dat_a = RST_BYTE;
		rf.dat_b = RST_BYTE;
		rf.swap_af = 1'b0;
		rf.swap_bank = 1'b0;
		idx = (s_r.pre == PRE_X) ? s_r.ix : s_r.iy; // see [RULE15]
		hl = {rf.regs[R_H], rf.regs[R_L]};
		grp = f_grp(s_r.op);
		dst = f_dst(s_r.op);
		src = f_src(s_r.op);
		lo4 = f_lo4(s_r.op);
		unique case (s_r.st)
			S_FETCH: begin
				if (mem_ready_i) begin
					s_nxt.pc = s_r.pc + ONE16; // see [RULE16]
					s_nxt.op = mem_rdata_i;
					if (mem_rdata_i == OP_PRE_X) begin
						s_nxt.pre = PRE_X; // see [RULE15]
					end else if (mem_rdata_i == OP_PRE_Y) begin
						s_nxt.pre = PRE_Y; // see [RULE15]
					end else if (mem_rdata_i == OP_PRE_ED) begin
						s_nxt.ed = 1'b1;
					end else begin
						s_nxt.st = S_DEC;
					end
				end
			end
			S_DEC: begin
				s_nxt.pp = f_pp(s_r.op);
				s_nxt.wimm = 1'b0;
				s_nxt.afsel = 1'b0;
				s_nxt.kind = K_NONE;
				if (s_r.ed) begin
					// The extended page has no indexed forms, so the prefix is dropped.
					s_nxt.pre = PRE_NONE;
					if (grp == GRP_MOVE && lo4 == LO4_ED_RD) begin
						s_nxt.kind = K_RD16; // see [RULE5]
						s_nxt.st = S_NNLO;
					end else if (grp == GRP_MOVE && lo4 == LO4_ED_WR) begin
						s_nxt.kind = K_WR16; // see [RULE5]
						s_nxt.st = S_NNLO;
					end else begin
						s_nxt.illegal = 1'b1;
						finish = 1'b1;
					end
				end else if (grp == GRP_MOVE && s_r.op != OP_HALT) begin
					s_nxt.addr = hl;
					if (src == R_MEM || dst == R_MEM) begin
						s_nxt.kind = (src == R_MEM) ? K_RD8 : K_WR8; // see [RULE14]
						s_nxt.reg_sel = (src == R_MEM) ? dst : src;
						if (s_r.pre != PRE_NONE) begin
							s_nxt.st = S_DISP; // see [RULE1]
						end else begin
							s_nxt.st = (src == R_MEM) ? S_RD1 : S_WR1;
						end
					end else begin
						rf.we_a = 1'b1; // see [RULE13]
						rf.sel_a = dst;
						rf.dat_a = rf.regs[src];
						finish = 1'b1;
					end
				end else if (grp == GRP_MISC && src == LO_IMM8) begin
					s_nxt.reg_sel = dst;
					s_nxt.addr = hl;
					if (dst == R_MEM) begin
						s_nxt.kind = K_WR8;
						s_nxt.wimm = 1'b1;
						// Displacement comes straight after the opcode, operand last.
						s_nxt.st = (s_r.pre != PRE_NONE) ? S_DISP : S_N; // see [RULE4]
					end else begin
						s_nxt.kind = K_IMM8; // see [RULE3]
						s_nxt.st = S_N;
					end
				end else if (s_r.op == OP_A_BC || s_r.op == OP_A_DE) begin
					s_nxt.kind = K_RD8;
					s_nxt.reg_sel = R_A;
					// The pair field is decoded in this cycle, so the pointer comes from the next copy.
					s_nxt.addr = pair_of(s_nxt, rf.regs);
					s_nxt.st = S_RD1;
				end else if (s_r.op == OP_BC_A || s_r.op == OP_DE_A) begin
					s_nxt.kind = K_WR8;
					s_nxt.reg_sel = R_A;
					s_nxt.addr = pair_of(s_nxt, rf.regs);
					s_nxt.st = S_WR1;
				end else if (s_r.op == OP_A_NN || s_r.op == OP_NN_A) begin
					s_nxt.kind = (s_r.op == OP_A_NN) ? K_RD8 : K_WR8; // see [RULE2]
					s_nxt.reg_sel = R_A;
					s_nxt.st = S_NNLO;
				end else if (s_r.op == OP_HL_NN || s_r.op == OP_NN_HL) begin
					s_nxt.kind = (s_r.op == OP_HL_NN) ? K_RD16 : K_WR16; // see [RULE5]
					s_nxt.st = S_NNLO;
				end else if (grp == GRP_MISC && lo4 == LO4_IMM16) begin
					s_nxt.kind = K_IMM16;
					s_nxt.st = S_NNLO;
				end else if (grp == GRP_STACK && (lo4 == LO4_POP || lo4 == LO4_PUSH)) begin
					s_nxt.afsel = 1'b1;
					s_nxt.st = (lo4 == LO4_POP) ? S_POP1 : S_PUSH1; // see [RULE11]
				end else if (s_r.op == OP_EX_AF) begin
					rf.swap_af = 1'b1; // see [RULE10]
					finish = 1'b1;
				end else if (s_r.op == OP_BANK_SWAP) begin
					rf.swap_bank = 1'b1; // see [RULE10]
					finish = 1'b1;
				end else if (s_r.op == OP_SP_HL) begin
					s_nxt.sp = (s_r.pre == PRE_NONE) ? hl : idx;
					finish = 1'b1;
				end else begin
					s_nxt.illegal = 1'b1;
					finish = 1'b1;
				end
			end
			S_DISP: begin
				if (mem_ready_i) begin
					s_nxt.pc = s_r.pc + ONE16;
					s_nxt.addr = ea; // see [RULE12]
					if (s_r.wimm) begin
						s_nxt.st = S_N; // see [RULE4]
					end else begin
						s_nxt.st = (s_r.kind == K_RD8) ? S_RD1 : S_WR1; // see [RULE1]
					end
				end
			end
			S_N: begin
				if (mem_ready_i) begin
					s_nxt.pc = s_r.pc + ONE16;
					s_nxt.lo = mem_rdata_i;
					if (s_r.kind == K_IMM8) begin
						rf.we_a = 1'b1; // see [RULE3]
						rf.sel_a = s_r.reg_sel;
						rf.dat_a = mem_rdata_i;
						finish = 1'b1;
					end else begin
						s_nxt.st = S_WR1;
					end
				end
			end
			S_NNLO: begin
				if (mem_ready_i) begin
					s_nxt.pc = s_r.pc + ONE16;
					s_nxt.lo = mem_rdata_i; // see [RULE9]
					s_nxt.st = S_NNHI;
				end
			end
			S_NNHI: begin
				if (mem_ready_i) begin
					s_nxt.pc = s_r.pc + ONE16;
					if (s_r.kind == K_IMM16) begin
						wp_go = 1'b1;
						wp_val = {mem_rdata_i, s_r.lo}; // see [RULE9]
						finish = 1'b1;
					end else begin
						s_nxt.addr = {mem_rdata_i, s_r.lo}; // see [RULE2]
						s_nxt.st = (s_r.kind == K_RD8 || s_r.kind == K_RD16) ? S_RD1 : S_WR1;
					end
				end
			end
			S_RD1: begin
				if (mem_ready_i) begin
					s_nxt.lo = mem_rdata_i;
					if (s_r.kind == K_RD8) begin
						rf.we_a = 1'b1;
						rf.sel_a = s_r.reg_sel;
						rf.dat_a = mem_rdata_i;
						finish = 1'b1;
					end else begin
						s_nxt.st = S_RD2;
					end
				end
			end
			S_RD2, S_POP2: begin
				if (mem_ready_i) begin
					if (s_r.st == S_POP2) begin
						s_nxt.sp = s_r.sp + ONE16; // see [RULE8]
					end
					wp_go = 1'b1;
					wp_val = {mem_rdata_i, s_r.lo}; // see [RULE7]
					finish = 1'b1;
				end
			end
			S_WR1: begin
				if (mem_ready_i) begin
					s_nxt.st = (s_r.kind == K_WR16) ? S_WR2 : S_FETCH;
					finish = (s_r.kind != K_WR16);
				end
			end
			S_WR2, S_PUSH2: begin
				if (mem_ready_i) begin
					if (s_r.st == S_PUSH2) begin
						s_nxt.sp = s_r.sp - ONE16; // see [RULE6]
					end
					finish = 1'b1;
				end
			end
			S_PUSH1: begin
				if (mem_ready_i) begin
					s_nxt.sp = s_r.sp - ONE16; // see [RULE6]
					s_nxt.st = S_PUSH2;
				end
			end
			S_POP1: begin
				if (mem_ready_i) begin
					s_nxt.lo = mem_rdata_i; // see [RULE8]
					s_nxt.sp = s_r.sp + ONE16;
					s_nxt.st = S_POP2;
				end
			end
		endcase
		if (finish) begin
			s_nxt.st = S_FETCH;
			s_nxt.pre = PRE_NONE;
			s_nxt.ed = 1'b0;
			s_nxt.done = 1'b1;
		end
		// Pair write-back; with a prefix pointer_pair lands in an index register.
		if (wp_go) begin
			unique case (s_r.pp)
				PP_BC, PP_DE: begin
					rf.we_a = 1'b1;
					rf.sel_a = (s_r.pp == PP_BC) ? R_B : R_D;
					rf.dat_a = wp_val[AW-1:DW];
					rf.we_b = 1'b1;
					rf.sel_b = (s_r.pp == PP_BC) ? R_C : R_E;
					rf.dat_b = wp_val[DW-1:0];
				end
				PP_HL: begin
					if (s_r.pre == PRE_X) begin
						s_nxt.ix = wp_val; // see [RULE15]
					end else if (s_r.pre == PRE_Y) begin
						s_nxt.iy = wp_val; // see [RULE15]
					end else begin
						rf.we_a = 1'b1;
						rf.sel_a = R_H;
						rf.dat_a = wp_val[AW-1:DW];
						rf.we_b = 1'b1;
						rf.sel_b = R_L;
						rf.dat_b = wp_val[DW-1:0];
					end
				end
				default: begin
					if (s_r.afsel) begin
						rf.we_a = 1'b1;
						rf.sel_a = R_A;
						rf.dat_a = wp_val[AW-1:DW];
						rf.we_b = 1'b1;
						rf.sel_b = R_F;
						rf.dat_b = wp_val[DW-1:0];
					end else begin
						s_nxt.sp = wp_val;
					end
				end
			endcase
		end
		// Address and write data are prepared one cycle ahead so the pins come from flops.
		unique case (s_nxt.st)
			S_RD1, S_WR1: s_nxt.maddr = s_nxt.addr;
			S_RD2, S_WR2: s_nxt.maddr = s_nxt.addr + ONE16;
			S_PUSH1, S_PUSH2: s_nxt.maddr = s_nxt.sp - ONE16; // see [RULE6]
			S_POP1, S_POP2: s_nxt.maddr = s_nxt.sp; // see [RULE8]
			S_FETCH, S_DEC, S_DISP, S_N, S_NNLO, S_NNHI: s_nxt.maddr = s_nxt.pc;
		endcase
		unique case (s_nxt.st)
			S_PUSH1, S_WR2: s_nxt.wdat = DW'(pair_of(s_nxt, rf.regs) >> DW); // see [RULE7]
			S_PUSH2: s_nxt.wdat = DW'(pair_of(s_nxt, rf.regs));
			S_WR1: begin
				if (s_nxt.kind == K_WR16) begin
					s_nxt.wdat = DW'(pair_of(s_nxt, rf.regs)); // see [RULE9]
				end else begin
					s_nxt.wdat = s_nxt.wimm ? s_nxt.lo : rf.regs[s_nxt.reg_sel];
				end
			end
			default: s_nxt.wdat = s_r.wdat;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r <= CORE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mem_req_o = (s_r.st != S_DEC);
	assign mem_we_o = (s_r.st inside {S_WR1, S_WR2, S_PUSH1, S_PUSH2});
	assign mem_addr_o = s_r.maddr;
	assign mem_wdata_o = s_r.wdat;
	assign instr_done_o = s_r.done;
	assign illegal_op_o = s_r.illegal;
	assign pc_o = s_r.pc;
	assign sp_o = s_r.sp;

	// ***********************************************
	// Checks
	// ***********************************************
	logic plain;
	logic [AW-1:0] disp_sx;
	assign plain = (s_r.pre == PRE_NONE) && !s_r.ed;
	assign disp_sx = {{(AW - DW){mem_rdata_i[DW-1]}}, mem_rdata_i};

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_idx_disp_next: assert property ((s_r.st == S_DEC) && !s_r.ed && s_r.pre != PRE_NONE && grp == GRP_MOVE && src == R_MEM && dst != R_MEM |=> s_r.st == S_DISP) else $error("indexed load skipped displacement"); // see [RULE1]
	a_nn_addr_order: assert property ((s_r.st == S_NNHI) && mem_ready_i && s_r.kind != K_IMM16 |=> s_r.addr == {$past(mem_rdata_i), s_r.lo}) else $error("direct address byte order wrong"); // see [RULE2] [RULE9]
	a_imm8_length: assert property ((s_r.st == S_DEC) && plain && s_r.op == OP_H_N |=> (s_r.st == S_N) && s_r.kind == K_IMM8 && s_r.reg_sel == R_H) else $error("immediate load to H misdecoded"); // see [RULE3]
	a_store_imm_seq: assert property ((s_r.st == S_DEC) && !s_r.ed && s_r.pre != PRE_NONE && s_r.op == OP_M_N |=> (s_r.st == S_DISP) && s_r.wimm) else $error("indexed immediate store order wrong"); // see [RULE4]
	a_pair_direct: assert property ((s_r.st == S_DEC) && plain && s_r.op == OP_NN_HL |=> (s_r.st == S_NNLO) && s_r.kind == K_WR16) else $error("pair store not direct"); // see [RULE5]
	a_push_pre_dec: assert property ((s_r.st == S_PUSH1) && mem_ready_i |=> s_r.sp == $past(s_r.sp) - ONE16 && mem_addr_o == s_r.sp - ONE16) else $error("push address not predecremented"); // see [RULE6]
	a_push_af_order: assert property ((s_r.st == S_PUSH1) && s_r.op == OP_PUSH_AF && mem_ready_i |-> mem_wdata_o == rf.regs[R_A] ##1 mem_wdata_o == rf.regs[R_F]) else $error("push order of accumulator and flags wrong"); // see [RULE6] [RULE7]
	a_pop_reverse: assert property ((s_r.st == S_POP1) && mem_ready_i |=> (s_r.st == S_POP2) && mem_addr_o == $past(mem_addr_o) + ONE16) else $error("pop does not step upward"); // see [RULE8]
	a_swap_af: assert property ((s_r.st == S_DEC) && plain && s_r.op == OP_EX_AF |-> rf.swap_af ##1 instr_done_o) else $error("exchange of acc_flag_pair missing"); // see [RULE10]
	a_sp_only_stack: assert property ((s_r.st inside {S_RD1, S_WR1, S_WR2, S_DISP}) |=> $stable(s_r.sp)) else $error("stack pointer moved outside stack access"); // see [RULE11]
	a_disp_signed: assert property ((s_r.st == S_DISP) && mem_ready_i |=> s_r.addr == $past(idx) + $past(disp_sx)) else $error("displacement not sign extended"); // see [RULE12]
	a_copy_b_c: assert property ((s_r.st == S_DEC) && plain && s_r.op == OP_C_B |=> rf.regs[R_C] == $past(rf.regs[R_B]) && instr_done_o) else $error("B to C copy failed"); // see [RULE13]
	a_store_d_hl: assert property ((s_r.st == S_DEC) && plain && s_r.op == OP_M_D |=> mem_we_o && mem_addr_o == $past(hl) && mem_wdata_o == rf.regs[R_D]) else $error("store of D through pointer_pair wrong"); // see [RULE14]
	a_prefix_redirect: assert property ((s_r.st == S_NNHI) && mem_ready_i && s_r.kind == K_IMM16 && s_r.pp == PP_HL && s_r.pre == PRE_X |=> s_r.ix == {$past(mem_rdata_i), s_r.lo}) else $error("prefixed pair load missed index_reg_x"); // see [RULE15]

	c_push_af: cover property ((s_r.st == S_PUSH2) && s_r.op == OP_PUSH_AF && mem_ready_i);
	c_pop_pair: cover property ((s_r.st == S_POP2) && mem_ready_i);
	c_idx_store_imm: cover property ((s_r.st == S_WR1) && s_r.wimm && s_r.pre != PRE_NONE && mem_ready_i);
	c_bank_swap: cover property (rf.swap_bank);
endmodule

/* File: verilog/lxd_pkg.sv */
// Shared constants and types of the load and exchange decoder.
package lxd_pkg;
	localparam int AW = 16;
	localparam int DW = 8;
	localparam int NREG = 8;
	// Registers 0 to 5 form the general bank that the bank swap exchanges.
	localparam int N_MAIN = 6;
	localparam logic [AW-1:0] RST_PC = 16'h0000;
	localparam logic [AW-1:0] RST_SP = 16'hFFFF;
	localparam logic [AW-1:0] ONE16 = 16'h0001;
	localparam logic [DW-1:0] RST_BYTE = 8'h00;
	localparam logic [DW-1:0] OP_PRE_X = 8'hDD;
	localparam logic [DW-1:0] OP_PRE_Y = 8'hFD;
	localparam logic [DW-1:0] OP_PRE_ED = 8'hED;
	localparam logic [DW-1:0] OP_EX_AF = 8'h08;
	localparam logic [DW-1:0] OP_BANK_SWAP = 8'hD9;
	localparam logic [DW-1:0] OP_SP_HL = 8'hF9;
	localparam logic [DW-1:0] OP_A_NN = 8'h3A;
	localparam logic [DW-1:0] OP_NN_A = 8'h32;
	localparam logic [DW-1:0] OP_HL_NN = 8'h2A;
	localparam logic [DW-1:0] OP_NN_HL = 8'h22;
	localparam logic [DW-1:0] OP_A_BC = 8'h0A;
	localparam logic [DW-1:0] OP_A_DE = 8'h1A;
	localparam logic [DW-1:0] OP_BC_A = 8'h02;
	localparam logic [DW-1:0] OP_DE_A = 8'h12;
	localparam logic [DW-1:0] OP_HALT = 8'h76;
	localparam logic [DW-1:0] OP_H_N = 8'h26;
	localparam logic [DW-1:0] OP_M_N = 8'h36;
	localparam logic [DW-1:0] OP_C_B = 8'h48;
	localparam logic [DW-1:0] OP_M_D = 8'h72;
	localparam logic [DW-1:0] OP_PUSH_AF = 8'hF5;
	localparam logic [1:0] GRP_MISC = 2'h0;
	localparam logic [1:0] GRP_MOVE = 2'h1;
	localparam logic [1:0] GRP_STACK = 2'h3;
	localparam logic [2:0] LO_IMM8 = 3'h6;
	localparam logic [3:0] LO4_IMM16 = 4'h1;
	localparam logic [3:0] LO4_POP = 4'h1;
	localparam logic [3:0] LO4_PUSH = 4'h5;
	localparam logic [3:0] LO4_ED_RD = 4'hB;
	localparam logic [3:0] LO4_ED_WR = 4'h3;
	localparam logic [2:0] R_B = 3'h0;
	localparam logic [2:0] R_C = 3'h1;
	localparam logic [2:0] R_D = 3'h2;
	localparam logic [2:0] R_E = 3'h3;
	localparam logic [2:0] R_H = 3'h4;
	localparam logic [2:0] R_L = 3'h5;
	localparam logic [2:0] R_MEM = 3'h6;
	localparam logic [2:0] R_F = 3'h6;
	localparam logic [2:0] R_A = 3'h7;
	localparam logic [1:0] PP_BC = 2'h0;
	localparam logic [1:0] PP_DE = 2'h1;
	localparam logic [1:0] PP_HL = 2'h2;

	function automatic logic [1:0] f_grp(input logic [DW-1:0] op);
		return op[7:6];
	endfunction
	function automatic logic [2:0] f_dst(input logic [DW-1:0] op);
		return op[5:3];
	endfunction
	function automatic logic [2:0] f_src(input logic [DW-1:0] op);
		return op[2:0];
	endfunction
	function automatic logic [1:0] f_pp(input logic [DW-1:0] op);
		return op[5:4];
	endfunction
	function automatic logic [3:0] f_lo4(input logic [DW-1:0] op);
		return op[3:0];
	endfunction

	typedef enum logic [3:0] {S_FETCH, S_DEC, S_DISP, S_N, S_NNLO, S_NNHI, S_RD1, S_RD2,
		S_WR1, S_WR2, S_PUSH1, S_PUSH2, S_POP1, S_POP2} lxd_state_type;
	typedef enum logic [1:0] {PRE_NONE, PRE_X, PRE_Y} lxd_pre_type;
	typedef enum logic [2:0] {K_NONE, K_IMM8, K_RD8, K_WR8, K_RD16, K_WR16, K_IMM16} lxd_kind_type;

	typedef struct packed {
		lxd_state_type st;
		logic [AW-1:0] pc, sp, ix, iy, addr, maddr;
		lxd_pre_type pre;
		lxd_kind_type kind;
		logic ed, wimm, afsel, done, illegal;
		logic [DW-1:0] op, lo, wdat;
		logic [2:0] reg_sel;
		logic [1:0] pp;
	} lxd_core_type;

	localparam lxd_core_type CORE_RST = '{st: S_FETCH, pc: RST_PC, sp: RST_SP, pre: PRE_NONE,
		kind: K_NONE, maddr: RST_PC, default: '0};

	typedef struct packed {
		logic [NREG-1:0][DW-1:0] main, alt;
	} lxd_bank_type;
endpackage

/* File: verilog/lxd_rf_if.sv */
// Link between the sequencer and the swappable register bank.
`timescale 1ns/1ns
interface lxd_rf_if;
	import lxd_pkg::*;
	logic [NREG-1:0][DW-1:0] regs;
	logic we_a, we_b, swap_af, swap_bank;
	logic [2:0] sel_a, sel_b;
	logic [DW-1:0] dat_a, dat_b;
	modport core (input regs, output we_a, we_b, sel_a, sel_b, dat_a, dat_b, swap_af, swap_bank);
	modport bank (output regs, input we_a, we_b, sel_a, sel_b, dat_a, dat_b, swap_af, swap_bank);
endinterface
